// ### shared/vfb_pkg.sv
// Constants and types for the virtual-function window configuration block
package vfb_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] VFB_OFS_CTRL  = 8'h00;
   localparam logic [7:0] VFB_OFS_STAT  = 8'h04;
   localparam logic [3:0] VFB_GRP_CFG   = 4'h1;  // 0x10..0x1C window type and size
   localparam logic [3:0] VFB_GRP_INFO  = 4'h2;  // 0x20..0x2C decoded window state
   localparam logic [3:0] VFB_GRP_BAR   = 4'h3;  // 0x30..0x3C window address words
   localparam logic [3:0] VFB_GRP_MASK  = 4'h4;  // 0x40..0x4C address mask, upper half for an odd window paired with its even partner

   // Field positions
   localparam int VFB_CTRL_VIRT_BIT = 0;
   localparam int VFB_CTRL_ARI_BIT  = 1;
   localparam int VFB_CFG_TYPE_LSB  = 0;
   localparam int VFB_CFG_SIZE_LSB  = 8;
   localparam int VFB_INFO_EN_BIT   = 0;
   localparam int VFB_INFO_IO_BIT   = 1;
   localparam int VFB_INFO_MEM_BIT  = 2;
   localparam int VFB_INFO_PF_BIT   = 3;
   localparam int VFB_INFO_64_BIT   = 4;
   localparam int VFB_INFO_RSV_BIT  = 5;
   localparam int VFB_INFO_SERR_BIT = 6;
   localparam int VFB_INFO_UPR_BIT  = 7;

   // Values after reset
   localparam logic [1:0] VFB_CTRL_RST = 2'h0;
   localparam logic [2:0] VFB_TYPE_RST = 3'h0;
   localparam logic [4:0] VFB_SIZE_RST = 5'h00;
   localparam logic [31:0] VFB_BAR_RST = 32'h0000_0000;

   // Window sizing: code 0 is 128 bytes, each step doubles
   localparam logic [5:0] VFB_SIZE_BASE_LOG2 = 6'd7;
   localparam logic [5:0] VFB_MAX32_LOG2     = 6'd31;
   localparam int         VFB_NUM_WIN        = 4;

   // Window type select codes
   typedef enum logic [2:0] {
      VFB_T_OFF   = 3'b000,
      VFB_T_IO    = 3'b001,
      VFB_T_RSV0  = 3'b010,
      VFB_T_RSV1  = 3'b011,
      VFB_T_M32   = 3'b100,
      VFB_T_M32PF = 3'b101,
      VFB_T_M64   = 3'b110,
      VFB_T_M64PF = 3'b111
   } vfb_type_t;

   // Bus data phase tracking
   typedef enum logic [1:0] {
      VFB_BUS_IDLE  = 2'b00,
      VFB_BUS_WRITE = 2'b01,
      VFB_BUS_RWAIT = 2'b10,
      VFB_BUS_RDONE = 2'b11
   } vfb_bus_t;

endpackage : vfb_pkg

// ### shared/vfb_dec_if.sv
// Signals between the register bank and one window decoder
`timescale 1ns/1ps
interface vfb_dec_if;
   logic [2:0]  type_sel;
   logic [4:0]  size_code;
   logic        pair_upper;
   logic        en;
   logic        io;
   logic        mem;
   logic        pf;
   logic        is64;
   logic        rsvd;
   logic        size_err;
   logic [31:0] fixed_bits;
   logic [31:0] lo_mask;
   logic [31:0] hi_mask;

   modport ctl (output type_sel, size_code, pair_upper,
                input  en, io, mem, pf, is64, rsvd, size_err, fixed_bits, lo_mask, hi_mask);
   modport dec (input  type_sel, size_code, pair_upper,
                output en, io, mem, pf, is64, rsvd, size_err, fixed_bits, lo_mask, hi_mask);
endinterface : vfb_dec_if

// ### rtl/vfb_window_decode.sv
// Decode of one window's type select and size code
`timescale 1ns/1ps
module vfb_window_decode #(
   parameter bit CAN_PAIR = 1'b1
) (
   vfb_dec_if.dec win
);
   import vfb_pkg::*;

   logic [5:0]  log2_sz;
   logic [63:0] mask64;

   // Type and size decode
   always_comb begin
      log2_sz        = VFB_SIZE_BASE_LOG2 + {1'b0, win.size_code};
      mask64         = ~((64'h0000_0000_0000_0001 << log2_sz) - 64'h0000_0000_0000_0001);
      win.en         = 1'b0;
      win.io         = 1'b0;
      win.mem        = 1'b0;
      win.pf         = 1'b0;
      win.is64       = 1'b0;
      win.rsvd       = 1'b0;
      win.size_err   = 1'b0;
      win.fixed_bits = 32'h0000_0000;
      win.lo_mask    = 32'h0000_0000;
      win.hi_mask    = 32'h0000_0000;
      if (!win.pair_upper) begin
         unique case (vfb_type_t'(win.type_sel))
            VFB_T_OFF: ;
            VFB_T_IO: begin
               win.en = 1'b1;
               win.io = 1'b1;
            end
            VFB_T_RSV0, VFB_T_RSV1: win.rsvd = 1'b1;
            VFB_T_M32, VFB_T_M32PF: begin
               win.en  = 1'b1;
               win.mem = 1'b1;
               win.pf  = win.type_sel[0];
            end
            VFB_T_M64, VFB_T_M64PF: begin
               if (CAN_PAIR) begin
                  win.en   = 1'b1;
                  win.mem  = 1'b1;
                  win.is64 = 1'b1;
                  win.pf   = win.type_sel[0];
               end else begin
                  win.rsvd = 1'b1;
               end
            end
         endcase
         // 32-bit windows cannot exceed the low address word
         win.size_err = win.en && !win.is64 && (log2_sz > VFB_MAX32_LOG2);
         if (win.en && !win.size_err) begin
            win.lo_mask = mask64[31:0];
            win.hi_mask = win.is64 ? mask64[63:32] : 32'h0000_0000;
            win.fixed_bits = win.io ? 32'h0000_0001
                           : {28'h000_0000, win.pf, win.is64, 2'b00};
         end
      end
   end
endmodule : vfb_window_decode

// ### rtl/vfb_bar_config.sv
// AHB-Lite register bank for virtual-function windows 2 to 5
`timescale 1ns/1ps
module vfb_bar_config #(
   parameter int HADDR_W = 32
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [HADDR_W-1:0]   haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic                      vf_cap_exposed,
   output logic [vfb_pkg::VFB_NUM_WIN-1:0] vf_window_on
);
   import vfb_pkg::*;

   // Elaboration check on the address width
   if (HADDR_W < 8) begin : g_bad_addr
      $error("HADDR_W must be at least 8");
   end

   vfb_bus_t    bus_reg, bus_next;
   logic [7:0]  addr_reg, addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic [1:0]  ctrl_reg, ctrl_next;
   logic [2:0]  type_reg [VFB_NUM_WIN];
   logic [2:0]  type_next [VFB_NUM_WIN];
   logic [4:0]  size_reg [VFB_NUM_WIN];
   logic [4:0]  size_next [VFB_NUM_WIN];
   logic [31:0] bar_reg [VFB_NUM_WIN];
   logic [31:0] bar_next [VFB_NUM_WIN];
   logic [VFB_NUM_WIN-1:0] win_on_reg, win_on_next;
   logic        exposed_reg, exposed_next;

   logic        cap_on;
   logic        take;
   logic [VFB_NUM_WIN-1:0] en_w, io_w, mem_w, pf_w, is64_w, rsv_w, serr_w, upr_w;
   logic [31:0] fix_w [VFB_NUM_WIN];
   logic [31:0] lo_w  [VFB_NUM_WIN];
   logic [31:0] hi_w  [VFB_NUM_WIN];
   logic [31:0] keep_w [VFB_NUM_WIN];
   logic [31:0] view_w [VFB_NUM_WIN];

   // Capability enable needs alternative routing too
   assign cap_on = ctrl_reg[VFB_CTRL_VIRT_BIT] & ctrl_reg[VFB_CTRL_ARI_BIT];

   // One decoder per window; an odd window follows its even partner only when that partner is 64-bit
   for (genvar i = 0; i < VFB_NUM_WIN; i++) begin : g_win
      vfb_dec_if dif ();
      vfb_window_decode #(
         .CAN_PAIR ((i % 2) == 0)
      ) u_dec (
         .win (dif)
      );
      assign dif.type_sel  = type_reg[i];
      assign dif.size_code = size_reg[i];
      if ((i % 2) == 1) begin : g_odd
         assign dif.pair_upper = is64_w[i-1];
         assign keep_w[i] = is64_w[i-1] ? hi_w[i-1] : lo_w[i];
      end else begin : g_even
         assign dif.pair_upper = 1'b0;
         assign keep_w[i] = lo_w[i];
      end
      assign en_w[i]   = dif.en;
      assign io_w[i]   = dif.io;
      assign mem_w[i]  = dif.mem;
      assign pf_w[i]   = dif.pf;
      assign is64_w[i] = dif.is64;
      assign rsv_w[i]  = dif.rsvd;
      assign serr_w[i] = dif.size_err;
      assign upr_w[i]  = dif.pair_upper;
      assign fix_w[i]  = dif.fixed_bits;
      assign lo_w[i]   = dif.lo_mask;
      assign hi_w[i]   = dif.hi_mask;
      // Window word as software sees it, hidden while the capability is off
      assign view_w[i] = cap_on ? ((bar_reg[i] & keep_w[i]) | fix_w[i])
                                : 32'h0000_0000;
   end

   assign take      = hsel & hready & htrans[1];
   assign hreadyout = (bus_reg != VFB_BUS_RWAIT);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;
   assign vf_cap_exposed = exposed_reg;
   assign vf_window_on   = win_on_reg;

   // Bus phase tracking, register writes and read data
   always_comb begin
      bus_next    = bus_reg;
      addr_next   = addr_reg;
      hrdata_next = hrdata_reg;
      ctrl_next   = ctrl_reg;
      type_next   = type_reg;
      size_next   = size_reg;
      bar_next    = bar_reg;
      unique case (bus_reg)
         VFB_BUS_WRITE: begin
            if (addr_reg == VFB_OFS_CTRL) begin
               ctrl_next = hwdata[1:0];
            end else if (addr_reg[7:4] == VFB_GRP_CFG) begin
               type_next[addr_reg[3:2]] = hwdata[VFB_CFG_TYPE_LSB +: 3];
               size_next[addr_reg[3:2]] = hwdata[VFB_CFG_SIZE_LSB +: 5];
            end else if (addr_reg[7:4] == VFB_GRP_BAR) begin
               bar_next[addr_reg[3:2]] = hwdata;      // Masked on read back
            end
         end
         VFB_BUS_RWAIT: begin
            hrdata_next = 32'h0000_0000;
            if (addr_reg == VFB_OFS_CTRL) begin
               hrdata_next = {30'h0000_0000, ctrl_reg};
            end else if (addr_reg == VFB_OFS_STAT) begin
               hrdata_next = {31'h0000_0000, cap_on};
            end else if (addr_reg[7:4] == VFB_GRP_CFG) begin
               hrdata_next[VFB_CFG_TYPE_LSB +: 3] = type_reg[addr_reg[3:2]];
               hrdata_next[VFB_CFG_SIZE_LSB +: 5] = size_reg[addr_reg[3:2]];
            end else if (addr_reg[7:4] == VFB_GRP_INFO && cap_on) begin
               hrdata_next[VFB_INFO_EN_BIT]   = en_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_IO_BIT]   = io_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_MEM_BIT]  = mem_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_PF_BIT]   = pf_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_64_BIT]   = is64_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_RSV_BIT]  = rsv_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_SERR_BIT] = serr_w[addr_reg[3:2]];
               hrdata_next[VFB_INFO_UPR_BIT]  = upr_w[addr_reg[3:2]];
            end else if (addr_reg[7:4] == VFB_GRP_BAR) begin
               hrdata_next = view_w[addr_reg[3:2]];
            end else if (addr_reg[7:4] == VFB_GRP_MASK && cap_on) begin
               hrdata_next = keep_w[addr_reg[3:2]];
            end
         end
         VFB_BUS_IDLE, VFB_BUS_RDONE: ;
      endcase
      // New address phase, accepted when hsel, hready and htrans[1] are high outside the read wait
      if (bus_reg == VFB_BUS_RWAIT) begin
         bus_next = VFB_BUS_RDONE;
      end else if (take) begin
         bus_next  = hwrite ? VFB_BUS_WRITE : VFB_BUS_RWAIT;
         addr_next = {haddr[7:2], 2'b00};
      end else begin
         bus_next = VFB_BUS_IDLE;
      end
   end

   // Registered window state outputs
   always_comb begin
      exposed_next = cap_on;
      win_on_next  = cap_on ? en_w : '0;
   end

   // State registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_reg     <= VFB_BUS_IDLE;
         addr_reg    <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
         ctrl_reg    <= VFB_CTRL_RST;
         win_on_reg  <= '0;
         exposed_reg <= 1'b0;
         for (int k = 0; k < VFB_NUM_WIN; k++) begin
            type_reg[k] <= VFB_TYPE_RST;
            size_reg[k] <= VFB_SIZE_RST;
            bar_reg[k]  <= VFB_BAR_RST;
         end
      end else begin
         bus_reg     <= bus_next;
         addr_reg    <= addr_next;
         hrdata_reg  <= hrdata_next;
         ctrl_reg    <= ctrl_next;
         win_on_reg  <= win_on_next;
         exposed_reg <= exposed_next;
         type_reg    <= type_next;
         size_reg    <= size_next;
         bar_reg     <= bar_next;
      end
   end

endmodule : vfb_bar_config

// ### test/vfb_chk.sv
// Bus timing and exposure checks for the window configuration bank
`timescale 1ns/1ps
module vfb_chk #(
   parameter int HADDR_W = 32
) (
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hsel,
   input wire logic [HADDR_W-1:0] haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic [2:0]         hsize,
   input wire logic [31:0]        hwdata,
   input wire logic               hready,
   input wire logic [31:0]        hrdata,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire logic               vf_cap_exposed,
   input wire logic [3:0]         vf_window_on
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Request and answer steps
   sequence s_rd_req; hsel && hready && htrans[1] && !hwrite; endsequence
   sequence s_wr_req; hsel && hready && htrans[1] && hwrite; endsequence
   sequence s_rd_phase; !hreadyout ##1 hreadyout; endsequence
   property p_okay; hresp == 1'b0; endproperty
   property p_rd_wait; s_rd_req |=> s_rd_phase; endproperty
   property p_wr_zero; s_wr_req |=> hreadyout; endproperty
   property p_idle_rdy; hreadyout && !(hsel && htrans[1]) |=> hreadyout; endproperty
   property p_one_wait; !hreadyout |=> hreadyout; endproperty
   property p_rd_hold; !$stable(hrdata) |-> !$past(hreadyout); endproperty
   property p_win_gate; !vf_cap_exposed |-> vf_window_on == 4'h0; endproperty
   property p_cap_rise;
      $rose(vf_cap_exposed) |-> $past(hwdata[1:0]) == 2'b11 || $past(hwdata[1:0], 2) == 2'b11;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   a_rd_wait: assert property (p_rd_wait) else $error("read data phase not two cycles");
   a_wr_zero: assert property (p_wr_zero) else $error("write data phase stalled");
   a_idle_rdy: assert property (p_idle_rdy) else $error("ready dropped while idle");
   a_one_wait: assert property (p_one_wait) else $error("ready low too long");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
   a_win_gate: assert property (p_win_gate) else $error("window on while hidden");
   a_cap_rise: assert property (p_cap_rise) else $error("exposed without both enables");
endmodule : vfb_chk

bind vfb_bar_config vfb_chk #(.HADDR_W(HADDR_W)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .vf_cap_exposed(vf_cap_exposed), .vf_window_on(vf_window_on));

// ### test/testbench.sv
// Register level bench for the window configuration bank
`timescale 1ns/1ps
module testbench;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        vf_cap_exposed;
   logic [3:0]  vf_window_on;
   int          miscompares = 0;
   int          comparisons = 0;
   // Expected decode per type code, and size probe table
   logic [7:0]  info_e[8] = '{8'h00, 8'h03, 8'h20, 8'h20, 8'h05, 8'h0D, 8'h15, 8'h1D};
   logic [7:0]  pc_a[10] = '{8'h10, 8'h10, 8'h10, 8'h14, 8'h14, 8'h14, 8'h18, 8'h18, 8'h18, 8'h18};
   logic [7:0]  pw_a[10] = '{8'h30, 8'h30, 8'h30, 8'h34, 8'h34, 8'h34, 8'h38, 8'h3C, 8'h38, 8'h3C};
   logic [15:0] pc_v[10] = '{16'h0004, 16'h0101, 16'h0205, 16'h0404, 16'h0805, 16'h1001,
                             16'h1E07, 16'h1E07, 16'h1F06, 16'h1F06};
   logic [31:0] pe[10] = '{32'hFFFF_FF80, 32'hFFFF_FF01, 32'hFFFF_FE08, 32'hFFFF_F800,
                           32'hFFFF_8008, 32'hFF80_0001, 32'h0000_000C, 32'hFFFF_FFE0,
                           32'h0000_0004, 32'hFFFF_FFC0};

   vfb_bar_config dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .vf_cap_exposed(vf_cap_exposed), .vf_window_on(vf_window_on));

   // Clock at 40 MHz
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   // Wait for ready seen high at a rising edge, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 20) begin
         n++;
         @(negedge hclk);
      end
      if (n >= 20) begin
         miscompares++;
         test_done();
      end else @(posedge hclk);
   endtask : wait_rdy

   // One single word transfer, entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h00_0000, a};
      wait_rdy();
      htrans <= 2'b00;
      if (wr) hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb

   task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [7:0] a);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t at %h got %h exp %h", $time, a, g, e);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr

   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0000_0000, x);
      cmp(x, e, a);
   endtask : chk

   // Look at the decoded outputs where settled
   task automatic chk_out(input logic c, input logic [3:0] w);
      @(negedge hclk);
      cmp({27'h0, vf_cap_exposed, vf_window_on}, {27'h0, c, w}, 8'hFF);
      @(posedge hclk);
   endtask : chk_out

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      chk(8'h00, 32'h0000_0000);
      chk(8'h10, 32'h0000_0000);
      $display("test reset done");
      // One enable alone keeps the windows hidden
      wr(8'h10, 32'h0000_0004);
      wr(8'h00, 32'h0000_0001);
      chk(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0000_0002);
      chk(8'h04, 32'h0000_0000);
      chk(8'h20, 32'h0000_0000);
      chk_out(1'b0, 4'h0);
      wr(8'h00, 32'h0000_0003);
      chk(8'h04, 32'h0000_0001);
      $display("test enables done");
      // Every type code on an even window
      for (int t = 0; t < 8; t++) begin
         wr(8'h10, t);
         chk(8'h20, {24'h00_0000, info_e[t]});
         chk_out(1'b1, {3'h0, info_e[t][0]});
      end
      wr(8'h10, 32'h0000_0004);
      wr(8'h14, 32'h0000_0006);
      chk(8'h24, 32'h0000_0020);
      $display("test types done");
      // Write all ones, read back the sized window word
      for (int i = 0; i < 10; i++) begin
         wr(pc_a[i], {16'h0000, pc_v[i]});
         wr(pw_a[i], 32'hFFFF_FFFF);
         chk(pw_a[i], pe[i]);
      end
      // Windows 2 and 3 standalone, 4 heads a pair with 5 as upper half
      chk_out(1'b1, 4'h7);
      chk(8'h2C, 32'h0000_0080);
      chk(8'h44, 32'hFF80_0000);
      chk(8'h4C, 32'hFFFF_FFC0);
      // Odd window sized beyond the low address word
      wr(8'h14, 32'h0000_1904);
      chk(8'h24, 32'h0000_0045);
      chk(8'h44, 32'h0000_0000);
      $display("test sizes done");
      wr(8'h80, 32'hFFFF_FFFF);
      chk(8'h80, 32'h0000_0000);
      wr(8'h04, 32'h0000_0000);
      chk(8'h04, 32'h0000_0001);
      wr(8'h00, 32'h0000_0001);
      chk(8'h38, 32'h0000_0000);
      chk_out(1'b0, 4'h0);
      $display("test access done");
      test_done();
   end
endmodule : testbench
